// >>> rtl/direct_io_pkg.sv
/*
 * Shared types and constants for the direct binary point exchange.
 * Assumes a single clock domain; channel frames arrive already decoded.
 */
package direct_io_pkg;

	localparam int unsigned POINTS_PER_CH = 8;
	localparam int unsigned NUM_CH        = 2;

	// reset values
	localparam logic [7:0] DEFAULTS_RST = 8'h00;
	localparam logic [7:0] OPERANDS_RST = 8'h00;
	localparam logic [2:0] SEL_RST      = 3'h0;

	// startup hold before received data is trusted, in ns and cycles
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned STARTUP_HOLD_NS = 200;
	localparam int unsigned STARTUP_CYCLES  =
		(STARTUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// per-channel receive view: frame valid strobe, points, health
	typedef struct packed {
		logic       frame_valid;
		logic [7:0] points;
		logic       failed;
	} rx_chan_t;

	// per-channel operand state
	typedef enum logic [1:0] {
		CH_STARTUP = 2'b00,
		CH_LIVE    = 2'b01,
		CH_FAILED  = 2'b11
	} ch_state_t;

endpackage

// >>> rtl/direct_in_channel.sv
/*
 * One channel of direct input operands: default on startup or failure,
 * received remote states otherwise, all zero while not active.
 * Assumes rx fields are synchronous to clk and failure is declared upstream.
 */
`timescale 1ns/1ps

module direct_in_channel #(
	parameter int unsigned N = direct_io_pkg::POINTS_PER_CH
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// configuration
	input  wire logic                    active,
	input  wire logic [N-1:0]            defaults,
	input  wire logic                    startup_done,
	// link side
	input  wire direct_io_pkg::rx_chan_t rx,
	// operand side
	output logic [N-1:0]                 operands,
	output direct_io_pkg::ch_state_t     state
);

	direct_io_pkg::ch_state_t state_q;
	direct_io_pkg::ch_state_t state_d;
	logic [N-1:0]             op_q;
	logic [N-1:0]             op_d;

	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		case (state_q)
			direct_io_pkg::CH_STARTUP: begin
				op_d = defaults;
				if (startup_done && !rx.failed && rx.frame_valid) begin
					state_d = direct_io_pkg::CH_LIVE;
					op_d    = rx.points;
				end
			end
			direct_io_pkg::CH_LIVE: begin
				if (rx.failed) begin
					state_d = direct_io_pkg::CH_FAILED;
					op_d    = defaults;
				end else if (rx.frame_valid) begin
					op_d = rx.points;
				end
			end
			direct_io_pkg::CH_FAILED: begin
				op_d = defaults;
				if (!rx.failed && rx.frame_valid) begin
					state_d = direct_io_pkg::CH_LIVE;
					op_d    = rx.points;
				end
			end
			default: begin
				state_d = direct_io_pkg::CH_STARTUP;
				op_d    = defaults;
			end
		endcase
		if (!active) begin
			state_d = direct_io_pkg::CH_STARTUP;
			op_d    = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= direct_io_pkg::CH_STARTUP;
			op_q    <= direct_io_pkg::OPERANDS_RST;
		end else begin
			state_q <= state_d;
			op_q    <= op_d;
		end
	end

	assign operands = op_q;
	assign state    = state_q;

	property p_fail_default;
		@(posedge clk) disable iff (!rst_n)
		(active && rx.failed && state_q == direct_io_pkg::CH_LIVE) |=> (op_q == $past(defaults));
	endproperty
	a_fail_default: assert property (p_fail_default) else $error("failed channel did not take default");

	property p_restore_follow;
		@(posedge clk) disable iff (!rst_n)
		(active && state_q == direct_io_pkg::CH_FAILED && !rx.failed && rx.frame_valid)
			|=> (state_q == direct_io_pkg::CH_LIVE && op_q == $past(rx.points));
	endproperty
	a_restore_follow: assert property (p_restore_follow) else $error("restored channel did not follow remote");

	property p_inactive_zero;
		@(posedge clk) disable iff (!rst_n)
		!active |=> (op_q == '0);
	endproperty
	a_inactive_zero: assert property (p_inactive_zero) else $error("operands active while disabled");

	property p_on_default;
		@(posedge clk) disable iff (!rst_n)
		(active && state_q == direct_io_pkg::CH_FAILED && rx.failed && defaults[0]) |=> op_q[0];
	endproperty
	a_on_default: assert property (p_on_default) else $error("on default not driven to one");

	property p_off_default;
		@(posedge clk) disable iff (!rst_n)
		(active && state_q == direct_io_pkg::CH_FAILED && rx.failed && !defaults[0]) |=> !op_q[0];
	endproperty
	a_off_default: assert property (p_off_default) else $error("off default not driven to zero");

endmodule // direct_in_channel

// >>> rtl/direct_io_points.sv
/*
 * Direct binary point exchange over one or two dedicated channels.
 * Assumes framing, channel supervision and operand selection settings come
 * from surrounding logic; all inputs synchronous to clk.
 */
// Functional notes
// - channel one gives eight input operands
// - channel two inputs only on three-terminal
// - send eight selected operands per channel
// - default on startup and channel failure
// - on default drives operand to one
// - restored channel follows remote outputs again
// - inputs inactive unless line differential enabled
`timescale 1ns/1ps

module direct_io_points #(
	parameter int unsigned N       = direct_io_pkg::POINTS_PER_CH,
	parameter int unsigned OPS     = 64,
	parameter int unsigned SEL_W   = 6
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// configuration
	input  wire logic                    line_differential_function,
	input  wire logic                    three_terminal,
	input  wire logic [N-1:0]            ch1_defaults,
	input  wire logic [N-1:0]            ch2_defaults,
	input  wire logic [N*SEL_W-1:0]      ch1_out_sel,
	input  wire logic [N*SEL_W-1:0]      ch2_out_sel,
	// local operand pool
	input  wire logic [OPS-1:0]          local_operands,
	// receive side
	input  wire direct_io_pkg::rx_chan_t ch1_rx,
	input  wire direct_io_pkg::rx_chan_t ch2_rx,
	// transmit side
	output logic [N-1:0]                 ch1_tx_points,
	output logic [N-1:0]                 ch2_tx_points,
	// input operands
	output logic [N-1:0]                 ch1_in_operands,
	output logic [N-1:0]                 ch2_in_operands,
	output logic                         startup_done
);

	localparam int unsigned CNT_W = $clog2(direct_io_pkg::STARTUP_CYCLES + 1);

	logic [CNT_W-1:0] start_cnt_q;
	logic [CNT_W-1:0] start_cnt_d;
	logic [N-1:0]     tx1_q;
	logic [N-1:0]     tx1_d;
	logic [N-1:0]     tx2_q;
	logic [N-1:0]     tx2_d;
	logic             ch2_active;

	// pick one operand for an output point; out-of-range selections read as zero
	function automatic logic pick(input logic [OPS-1:0] pool, input logic [SEL_W-1:0] sel);
		logic r;
		r = 1'b0;
		if (int'(sel) < OPS) begin
			r = pool[sel];
		end
		return r;
	endfunction

	// startup hold counter
	always_comb begin
		start_cnt_d = start_cnt_q;
		if (start_cnt_q != CNT_W'(direct_io_pkg::STARTUP_CYCLES)) begin
			start_cnt_d = start_cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			start_cnt_q <= '0;
		end else begin
			start_cnt_q <= start_cnt_d;
		end
	end

	assign startup_done = (start_cnt_q == CNT_W'(direct_io_pkg::STARTUP_CYCLES));

	always_comb begin
		tx1_d = '0;
		tx2_d = '0;
		for (int i = 0; i < int'(N); i++) begin
			tx1_d[i] = pick(local_operands, ch1_out_sel[i*SEL_W +: SEL_W]);
			tx2_d[i] = pick(local_operands, ch2_out_sel[i*SEL_W +: SEL_W]);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx1_q <= direct_io_pkg::OPERANDS_RST;
			tx2_q <= direct_io_pkg::OPERANDS_RST;
		end else begin
			tx1_q <= tx1_d;
			tx2_q <= tx2_d;
		end
	end

	assign ch1_tx_points = tx1_q;
	assign ch2_tx_points = tx2_q;

	assign ch2_active = line_differential_function && three_terminal;

	direct_in_channel #(
		.N (N)
	) u_ch1 (
		.clk          (clk),
		.rst_n        (rst_n),
		.active       (line_differential_function),
		.defaults     (ch1_defaults),
		.startup_done (startup_done),
		.rx           (ch1_rx),
		.operands     (ch1_in_operands),
		.state        ()
	);

	direct_in_channel #(
		.N (N)
	) u_ch2 (
		.clk          (clk),
		.rst_n        (rst_n),
		.active       (ch2_active),
		.defaults     (ch2_defaults),
		.startup_done (startup_done),
		.rx           (ch2_rx),
		.operands     (ch2_in_operands),
		.state        ()
	);

	property p_tx_follows;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (ch1_tx_points[0] == $past(pick(local_operands, ch1_out_sel[SEL_W-1:0])));
	endproperty
	a_tx_follows: assert property (p_tx_follows) else $error("outgoing point not the selected operand");

	property p_ch2_off;
		@(posedge clk) disable iff (!rst_n)
		!three_terminal |=> (ch2_in_operands == '0);
	endproperty
	a_ch2_off: assert property (p_ch2_off) else $error("channel two inputs on two-terminal system");

	property p_startup_default;
		@(posedge clk) disable iff (!rst_n)
		(!startup_done && line_differential_function) |=> (ch1_in_operands == $past(ch1_defaults));
	endproperty
	a_startup_default: assert property (p_startup_default) else $error("startup default not applied");

	property p_ch1_live;
		@(posedge clk) disable iff (!rst_n)
		(startup_done && line_differential_function && !ch1_rx.failed && ch1_rx.frame_valid)
			|=> (ch1_in_operands == $past(ch1_rx.points));
	endproperty
	a_ch1_live: assert property (p_ch1_live) else $error("channel one operands not received values");

	property p_tx_last;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (ch1_tx_points[N-1] == $past(pick(local_operands, ch1_out_sel[N*SEL_W-1 -: SEL_W])));
	endproperty
	a_tx_last: assert property (p_tx_last) else $error("last outgoing point not the selected operand");

	property p_tx2_follows;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (ch2_tx_points[0] == $past(pick(local_operands, ch2_out_sel[SEL_W-1:0])));
	endproperty
	a_tx2_follows: assert property (p_tx2_follows) else $error("channel two point not the selected operand");

	property p_ch2_live;
		@(posedge clk) disable iff (!rst_n)
		(startup_done && ch2_active && !ch2_rx.failed && ch2_rx.frame_valid)
			|=> (ch2_in_operands == $past(ch2_rx.points));
	endproperty
	a_ch2_live: assert property (p_ch2_live) else $error("channel two operands not received values");

	property p_ch1_fail;
		@(posedge clk) disable iff (!rst_n)
		(line_differential_function && ch1_rx.failed) |=> (ch1_in_operands == $past(ch1_defaults));
	endproperty
	a_ch1_fail: assert property (p_ch1_fail) else $error("channel one failure did not give defaults");

	property p_ch2_fail;
		@(posedge clk) disable iff (!rst_n)
		(ch2_active && ch2_rx.failed) |=> (ch2_in_operands == $past(ch2_defaults));
	endproperty
	a_ch2_fail: assert property (p_ch2_fail) else $error("channel two failure did not give defaults");

	property p_ch2_startup;
		@(posedge clk) disable iff (!rst_n)
		(!startup_done && ch2_active) |=> (ch2_in_operands == $past(ch2_defaults));
	endproperty
	a_ch2_startup: assert property (p_ch2_startup) else $error("channel two startup default not applied");

	property p_disabled_zero;
		@(posedge clk) disable iff (!rst_n)
		!line_differential_function |=> (ch1_in_operands == '0 && ch2_in_operands == '0);
	endproperty
	a_disabled_zero: assert property (p_disabled_zero) else $error("operands live without line differential");

	// hold ends once
	// only a reset restarts the startup hold; a channel made inactive and active again takes defaults until a frame
	property p_startup_holds;
		@(posedge clk) disable iff (!rst_n)
		startup_done |=> startup_done;
	endproperty
	a_startup_holds: assert property (p_startup_holds) else $error("startup hold restarted without reset");

	property p_ch1_hold;
		@(posedge clk) disable iff (!rst_n)
		(line_differential_function && !ch1_rx.failed && !ch1_rx.frame_valid
			&& $past(startup_done && line_differential_function && !ch1_rx.failed && ch1_rx.frame_valid))
			|=> $stable(ch1_in_operands);
	endproperty
	a_ch1_hold: assert property (p_ch1_hold) else $error("channel one operands moved without a frame");

endmodule // direct_io_points

// >>> verification/remote_relay_model.sv
/*
 * Remote relay stand-in for one dedicated channel: sends frames of chosen operands.
 * Assumes the local clock and a testbench that sets send, fail and ops.
 */
`timescale 1ns/1ps

module remote_relay_model (
	// clock
	input  wire logic               clk,
	// remote settings
	input  wire logic               send,
	input  wire logic               fail,
	input  wire logic [7:0]         ops,
	// link
	output direct_io_pkg::rx_chan_t rx
);
	initial rx = '0;
	always @(posedge clk) begin
		rx.frame_valid <= send;
		// operand onto point
		// no frame: lines invert every cycle, alternating between the last frame and its inverse
		rx.points      <= send ? ops : ~rx.points;
		rx.failed      <= fail;
	end
endmodule // remote_relay_model

// >>> verification/direct_io_channel_points_test.sv
/*
 * Self-checking bench for direct_io_points: table of frames, then awkward cases.
 * Assumes the package constants and the design's default parameters.
 */
`timescale 1ns/1ps

module direct_io_channel_points_test;
	typedef struct packed {
		logic [7:0]  p1;
		logic [7:0]  p2;
		logic [63:0] lo;
	} row_t;
	logic                    clk, rst_n, ldf, tt, sd, f1, f2, v1;
	logic [7:0]              d1, d2, t1, t2, i1, i2, p1, p2;
	logic [47:0]             s1, s2;
	logic [63:0]             lo;
	direct_io_pkg::rx_chan_t r1, r2;
	int                      num_errors, tests_run, k;
	row_t rows [4] = '{'{8'h01, 8'h80, 64'h0000_0000_0000_00FF}, '{8'hFF, 8'h00, 64'hFF00_0000_0000_0000},
		'{8'h5A, 8'hA5, 64'h8000_0000_0000_0001}, '{8'h00, 8'hFF, 64'h0123_4567_89AB_CDEF}};

	remote_relay_model far1 (.clk(clk), .send(v1), .fail(f1), .ops(p1), .rx(r1));
	remote_relay_model far2 (.clk(clk), .send(1'b1), .fail(f2), .ops(p2), .rx(r2));
	direct_io_points dut (.clk(clk), .rst_n(rst_n), .line_differential_function(ldf), .three_terminal(tt),
		.ch1_defaults(d1), .ch2_defaults(d2), .ch1_out_sel(s1), .ch2_out_sel(s2), .local_operands(lo),
		.ch1_rx(r1), .ch2_rx(r2), .ch1_tx_points(t1), .ch2_tx_points(t2), .ch1_in_operands(i1),
		.ch2_in_operands(i2), .startup_done(sd));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [7:0] txe(input logic [63:0] l, input logic [47:0] s);
		for (int i = 0; i < 8; i++) txe[i] = l[s[i*6+:6]];
	endfunction

	task tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task summarize;
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		{rst_n, f1, f2, lo, num_errors, tests_run} = '0;
		{ldf, tt, v1, d1, d2, p1, p2} = {3'h7, 8'hA5, 8'h3C, 8'hFF, 8'hFF};
		for (k = 0; k < 8; k++) {s1[k*6+:6], s2[k*6+:6]} = {6'(k), 6'(63 - k)};
		tick(3);
		chk("reset ch1_in", 8'h00, i1);
		chk("reset ch1_tx", 8'h00, t1);
		chk("reset startup_done", 8'h00, {7'h0, sd});
		@(posedge clk) rst_n <= 1'b1;
		tick(5);
		chk("startup ch1_in", d1, i1);
		chk("startup ch2_in", d2, i2);
		chk("startup_done early", 8'h00, {7'h0, sd});
		k = 0;
		while (sd !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		if (k == 20) begin
			num_errors++;
			summarize();
		end
		// frames come back to back, every cycle
		foreach (rows[r]) begin
			@(posedge clk) {p1, p2, lo} <= rows[r];
			tick(3);
			chk("ch1_in", rows[r].p1, i1);
			chk("ch2_in", rows[r].p2, i2);
			chk("ch1_tx", txe(rows[r].lo, s1), t1);
			chk("ch2_tx", txe(rows[r].lo, s2), t2);
		end
		@(posedge clk) f1 <= 1'b1;
		tick(3);
		chk("failed ch1_in", d1, i1);
		chk("healthy ch2_in", p2, i2);
		@(posedge clk) {f1, p1} <= {1'b0, 8'h96};
		tick(3);
		chk("restored ch1_in", 8'h96, i1);
		// no frames: the model shows changing lines that must be ignored
		@(posedge clk) {v1, p1} <= {1'b0, 8'h3C};
		tick(3);
		chk("no frame ch1_in", 8'h96, i1);
		@(posedge clk) v1 <= 1'b1;
		tick(3);
		chk("next frame ch1_in", 8'h3C, i1);
		@(posedge clk) f2 <= 1'b1;
		tick(3);
		chk("failed ch2_in", d2, i2);
		@(posedge clk) f2 <= 1'b0;
		tick(3);
		chk("restored ch2_in", p2, i2);
		@(posedge clk) tt <= 1'b0;
		tick(3);
		chk("two terminal ch2_in", 8'h00, i2);
		chk("two terminal ch1_in", 8'h3C, i1);
		@(posedge clk) ldf <= 1'b0;
		tick(3);
		chk("disabled ch1_in", 8'h00, i1);
		chk("disabled ch2_in", 8'h00, i2);
		@(posedge clk) {ldf, tt, rst_n} <= 3'h6;
		tick(2);
		chk("mid reset ch1_in", 8'h00, i1);
		chk("mid reset startup_done", 8'h00, {7'h0, sd});
		@(posedge clk) rst_n <= 1'b1;
		tick(2);
		chk("restart ch1_in", d1, i1);
		chk("restart ch2_in", d2, i2);
		summarize();
	end
endmodule // direct_io_channel_points_test
